// [include/mdsc_defines.svh]
// timing counts, thresholds and scale values of the demand front end
`ifndef MDSC_DEFINES_SVH
`define MDSC_DEFINES_SVH
// reference clock rate
`define MDSC_CLK_HZ        20000000
`define MDSC_CYC_PER_MS    (`MDSC_CLK_HZ / 1000)
// demand pin low time before standby, longer than this
`define MDSC_STBY_MS       1000
`define MDSC_STBY_CYC      (`MDSC_STBY_MS * `MDSC_CYC_PER_MS)
// frequency gate window for clock mode, result in hertz
`define MDSC_GATE_MS       1000
`define MDSC_GATE_CYC      (`MDSC_GATE_MS * `MDSC_CYC_PER_MS)
// no-edge timeout of the duty meter, per frequency range
`define MDSC_TOUT_HI_MS    1
`define MDSC_TOUT_HI_CYC   (`MDSC_TOUT_HI_MS * `MDSC_CYC_PER_MS)
`define MDSC_TOUT_LO_MS    25
`define MDSC_TOUT_LO_CYC   (`MDSC_TOUT_LO_MS * `MDSC_CYC_PER_MS)
// soft ramp step period and step size
`define MDSC_RAMP_US       10
`define MDSC_RAMP_CYC      (`MDSC_RAMP_US * (`MDSC_CLK_HZ / 1000000))
`define MDSC_RAMP_STEP     10'h008
// demand scale: full scale is 512
`define MDSC_FULL          10'h200
// off / on thresholds in 1/512 of full demand
`define MDSC_OFF0          10'h01e
`define MDSC_ON0           10'h028
`define MDSC_OFF1          10'h032
`define MDSC_ON1           10'h03c
`define MDSC_OFF2          10'h042
`define MDSC_ON2           10'h04d
`define MDSC_OFF3          10'h064
`define MDSC_ON3           10'h06f
`endif

// [include/mdsc_pkg.sv]
// types shared by the demand front end
package mdsc_pkg;
  typedef enum logic [1:0] {
    MDSC_MODE_DUTY   = 2'b00,
    MDSC_MODE_ANALOG = 2'b01,
    MDSC_MODE_CLOCK  = 2'b10
  } mdsc_mode_e;
  typedef enum logic [1:0] {
    MDSC_LOOP_OPEN  = 2'b00,
    MDSC_LOOP_SPEED = 2'b01,
    MDSC_LOOP_CURR  = 2'b10,
    MDSC_LOOP_POWER = 2'b11
  } mdsc_loop_e;
  typedef enum logic {
    MDSC_ST_ACTIVE  = 1'b0,
    MDSC_ST_STANDBY = 1'b1
  } mdsc_state_e;
  // static configuration
  typedef struct packed {
    mdsc_mode_e mode;
    mdsc_loop_e loop;
    logic [15:0] loopFullScale;
    logic [7:0]  clkRatio;
    logic [15:0] ratedSpeed;
    logic [1:0]  thrSel;
    logic        standbyEn;
    logic        stillChkEn;
    logic [1:0]  clkSrc;
    logic        inputFreqRangeSel;
    logic        safeBrakeEn;
    logic [15:0] safeBrakeSpeed;
    logic        softRampOnOff;
    logic [8:0]  demandFullScaleVoltage;
    logic [8:0]  standbyEnterLevel;
    logic [8:0]  standbyExitLevel;
  } mdsc_cfg_s;
  // register overrides from the two-wire side
  typedef struct packed {
    logic       demandSel;
    logic [8:0] regDemand;
    logic       dirOvrEn;
    logic       regDir;
    logic       haltOverrideEn;
    logic       regHalt;
  } mdsc_ovr_s;
  // targets handed to the control loop
  typedef struct packed {
    logic [19:0] loopTarget;
    logic [9:0]  openAmp;
  } mdsc_tgt_s;
endpackage : mdsc_pkg

// [rtl/mdsc_core.sv]
// demand decoding, stop hysteresis, standby, direction, brake and soft ramp
`timescale 1ns/1ns
`include "mdsc_defines.svh"
module mdsc_core
  import mdsc_pkg::*;
#(
  parameter int STBY_CYC    = `MDSC_STBY_CYC,
  parameter int GATE_CYC    = `MDSC_GATE_CYC,
  parameter int TOUT_HI_CYC = `MDSC_TOUT_HI_CYC,
  parameter int TOUT_LO_CYC = `MDSC_TOUT_LO_CYC
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        demandPin,       // raw demand pin
  input  wire logic        dirPin,          // raw direction pin
  input  wire logic        brakePin,        // raw brake pin
  input  wire logic [8:0]  adcCode,         // sampled demand voltage
  input  wire mdsc_cfg_s   cfg,             // configuration
  input  wire mdsc_ovr_s   ovr,             // register overrides
  input  wire logic [15:0] motorSpeed,      // rotor speed, rpm
  input  wire logic        motorStill,      // rotor stationary
  input  wire logic        windmillFwd,     // spinning forward already
  input  wire logic        curLimitActive,  // current limit engaged
  input  wire logic        maxVoltReached,  // output voltage at maximum
  output mdsc_tgt_s        tgt,             // loop targets
  output logic             motorRun,        // motor commanded to run
  output logic             clkInputErr,     // clock input error
  output logic             standby,         // standby state
  output logic             powerDown,       // pump and regulator off
  output logic             phaseFwd,        // 1: a-b-c, 0: a-c-b
  output logic             lowSideAllOn,    // all low sides on
  output logic [9:0]       currentScale,    // soft ramp scale
  output logic             satVoltage,      // saturated at max voltage
  output logic             satCurrent,      // saturated at current limit
  output logic             twoWireDemand,   // demand taken from registers
  output logic             sclLine          // synced serial clock line
);
  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  // threshold lookup; on selects the restart level
  function automatic logic [9:0] mdsc_thr(input logic [1:0] sel, input logic on);
    case (sel)
      2'b00:   mdsc_thr = on ? `MDSC_ON0 : `MDSC_OFF0;
      2'b01:   mdsc_thr = on ? `MDSC_ON1 : `MDSC_OFF1;
      2'b10:   mdsc_thr = on ? `MDSC_ON2 : `MDSC_OFF2;
      default: mdsc_thr = on ? `MDSC_ON3 : `MDSC_OFF3;
    endcase
  endfunction : mdsc_thr

  //----------------------------------------------------------------
  // input synchronisers
  //----------------------------------------------------------------
  logic [2:0]  pinRaw;      // brake, direction, demand
  logic [2:0]  pinSync;     // second stage outputs
  logic [2:0]  pinPrev_r;   // edge detect stage
  logic [2:0]  pinRise;     // one-cycle rising edges
  assign pinRaw = {brakePin, dirPin, demandPin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      logic s1_r;   // read only by s2_r
      logic s2_r;
      always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end
        else
        begin
          s1_r <= pinRaw[gi];
          s2_r <= s1_r;
        end
      assign pinSync[gi] = s2_r;
    end
  endgenerate
  // edge stage looks at the second flop only
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      pinPrev_r <= 3'h0;
    else
      pinPrev_r <= pinSync;
  assign pinRise = pinSync & ~pinPrev_r;
  assign sclLine = pinSync[0];

  //----------------------------------------------------------------
  // pin roles
  //----------------------------------------------------------------
  logic clkMode;     // clock mode active
  logic clkRise;     // edge of the chosen clock pin
  logic brakeSrc;    // brake pin unless it carries the clock
  logic brakeReq;    // brake request after override
  assign clkMode  = (cfg.mode == MDSC_MODE_CLOCK);
  // clock comes from demand by default, else dir or brake pin
  assign clkRise  = (cfg.clkSrc == 2'b01) ? pinRise[1] :
                    (cfg.clkSrc == 2'b10) ? pinRise[2] : pinRise[0];
  assign brakeSrc = pinSync[2] & ~(clkMode && cfg.clkSrc == 2'b10);
  assign brakeReq = ovr.haltOverrideEn ? ovr.regHalt : brakeSrc;

  //----------------------------------------------------------------
  // duty meter
  //----------------------------------------------------------------
  logic [24:0] hiCnt_r;    // high cycles this period
  logic [24:0] perCnt_r;   // cycles this period
  logic [24:0] measHi_r;   // last high time
  logic [24:0] measPer_r;  // last period
  logic [24:0] toutCyc;    // no-edge timeout for selected range
  assign toutCyc = cfg.inputFreqRangeSel ? 25'(TOUT_LO_CYC) : 25'(TOUT_HI_CYC);
  // a stuck pin reads as 0 or 100 percent after the timeout
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      hiCnt_r   <= 25'h0;
      perCnt_r  <= 25'h0;
      measHi_r  <= 25'h0;
      measPer_r <= 25'h0;
    end
    else if (pinRise[0])
    begin
      measHi_r  <= hiCnt_r;
      measPer_r <= perCnt_r;
      hiCnt_r   <= 25'h1;
      perCnt_r  <= 25'h1;
    end
    else if (perCnt_r >= toutCyc)
    begin
      measHi_r  <= {24'h0, pinSync[0]};
      measPer_r <= 25'h1;
    end
    else
    begin
      perCnt_r <= perCnt_r + 25'h1;
      hiCnt_r  <= hiCnt_r + {24'h0, pinSync[0]};
    end

  //----------------------------------------------------------------
  // frequency meter, one gate window per result
  //----------------------------------------------------------------
  logic [24:0] gateCnt_r;   // gate window counter
  logic [11:0] edgeCnt_r;   // edges in this window
  logic [11:0] freqHz_r;    // last frequency, hertz
  logic [19:0] rpmVal;      // commanded rpm
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      gateCnt_r <= 25'h0;
      edgeCnt_r <= 12'h0;
      freqHz_r  <= 12'h0;
    end
    else if (gateCnt_r == 25'(GATE_CYC - 1))
    begin
      gateCnt_r <= 25'h0;
      freqHz_r  <= edgeCnt_r;
      edgeCnt_r <= {11'h0, clkRise};
    end
    else
    begin
      gateCnt_r <= gateCnt_r + 25'h1;
      // saturate instead of wrapping on a wild input
      if (clkRise && edgeCnt_r != 12'hfff)
        edgeCnt_r <= edgeCnt_r + 12'h1;
    end
  assign rpmVal = 20'(freqHz_r * cfg.clkRatio);

  //----------------------------------------------------------------
  // shared ratio divider: quotient = num * 512 / den, max 512
  //----------------------------------------------------------------
  logic [24:0] srcNum;      // numerator of the mode
  logic [24:0] srcDen;      // denominator of the mode
  logic [3:0]  divStep_r;   // 0 loads, 1..9 produce bits
  logic [25:0] divRem_r;    // partial remainder
  logic [24:0] divDen_r;    // latched denominator
  logic [8:0]  divQ_r;      // quotient bits
  logic        divSat_r;    // num >= den or den zero
  logic        divZero_r;   // den zero
  logic [9:0]  demandMeas_r;// measured demand, 0..512
  logic [25:0] remSh;       // shifted remainder
  always_comb
  begin
    case (cfg.mode)
      MDSC_MODE_ANALOG:
      begin
        srcNum = {16'h0, adcCode};
        srcDen = {16'h0, cfg.demandFullScaleVoltage};
      end
      MDSC_MODE_CLOCK:
      begin
        srcNum = {5'h0, rpmVal};
        srcDen = {9'h0, cfg.ratedSpeed};
      end
      default:
      begin
        srcNum = measHi_r;
        srcDen = measPer_r;
      end
    endcase
  end
  assign remSh = {divRem_r[24:0], 1'b0};
  // one result every ten cycles; area traded for latency
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      divStep_r    <= 4'h0;
      divRem_r     <= 26'h0;
      divDen_r     <= 25'h0;
      divQ_r       <= 9'h0;
      divSat_r     <= 1'b0;
      divZero_r    <= 1'b0;
      demandMeas_r <= 10'h0;
    end
    else if (divStep_r == 4'h0)
    begin
      divRem_r  <= {1'b0, srcNum};
      divDen_r  <= srcDen;
      divQ_r    <= 9'h0;
      divZero_r <= (srcDen == 25'h0);
      divSat_r  <= (srcNum >= srcDen);
      divStep_r <= 4'h1;
    end
    else
    begin
      if (remSh >= {1'b0, divDen_r})
      begin
        divRem_r <= remSh - {1'b0, divDen_r};
        divQ_r   <= {divQ_r[7:0], 1'b1};
      end
      else
      begin
        divRem_r <= remSh;
        divQ_r   <= {divQ_r[7:0], 1'b0};
      end
      if (divStep_r == 4'h9)
      begin
        divStep_r <= 4'h0;
        if (divZero_r)
          demandMeas_r <= 10'h0;
        else if (divSat_r)
          demandMeas_r <= `MDSC_FULL;
        else
          demandMeas_r <= {1'b0, divQ_r[7:0], (remSh >= {1'b0, divDen_r})};
      end
      else
        divStep_r <= divStep_r + 4'h1;
    end

  //----------------------------------------------------------------
  // demand source, stop hysteresis, clock error
  //----------------------------------------------------------------
  logic        twoWire_r;   // demand latched to registers
  logic [9:0]  demand;      // effective demand, 0..512
  logic        runEn_r;     // hysteresis state
  logic        clkErr_r;    // clock overspeed
  logic        brakeOn;     // low sides requested
  mdsc_state_e state_r;
  assign demand = twoWire_r ? {1'b0, ovr.regDemand} : demandMeas_r;
  // below off stops, above on restarts, between holds
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      runEn_r <= 1'b0;
    else if (demand < mdsc_thr(cfg.thrSel, 1'b0))
      runEn_r <= 1'b0;
    else if (demand > mdsc_thr(cfg.thrSel, 1'b1))
      runEn_r <= 1'b1;
  // overspeed request is an error while it lasts
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      clkErr_r <= 1'b0;
    else
      clkErr_r <= clkMode && !twoWire_r &&
                  ({1'b0, rpmVal} > {4'h0, cfg.ratedSpeed, 1'b0});
  assign clkInputErr = clkErr_r;
  // brake overrides demand
  assign motorRun = runEn_r && !clkErr_r && !brakeReq &&
                    (state_r == MDSC_ST_ACTIVE);

  //----------------------------------------------------------------
  // loop targets and saturation report
  //----------------------------------------------------------------
  logic [25:0] scaled;      // full scale times demand
  assign scaled = cfg.loopFullScale * demand;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      tgt        <= '0;
      satVoltage <= 1'b0;
      satCurrent <= 1'b0;
    end
    else
    begin
      tgt.openAmp <= (cfg.loop == MDSC_LOOP_OPEN && !clkMode) ? demand : 10'h0;
      if (clkMode && !twoWire_r)
        tgt.loopTarget <= rpmVal;
      else if (cfg.loop == MDSC_LOOP_OPEN)
        tgt.loopTarget <= 20'h0;
      else
        tgt.loopTarget <= {3'h0, scaled[25:9]};
      // current limit takes over from the voltage ceiling
      satCurrent <= motorRun && curLimitActive;
      satVoltage <= motorRun && maxVoltReached && !curLimitActive;
    end

  //----------------------------------------------------------------
  // standby control
  //----------------------------------------------------------------
  logic [24:0] lowCnt_r;    // cycles the entry condition held
  logic        lowCond;     // entry condition this cycle
  logic        wake;        // exit condition
  // demand pin decides outside analog mode, even when the clock is elsewhere; analog mode compares adcCode
  assign lowCond = (cfg.mode == MDSC_MODE_ANALOG ?
                    (adcCode < cfg.standbyEnterLevel) : !pinSync[0]) &&
                   (motorStill || !cfg.stillChkEn) &&
                   !brakeReq && cfg.standbyEn;
  assign wake = (cfg.mode == MDSC_MODE_ANALOG) ?
                (adcCode > cfg.standbyExitLevel) : pinRise[0];
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      lowCnt_r <= 25'h0;
    else if (!lowCond || state_r != MDSC_ST_ACTIVE)
      lowCnt_r <= 25'h0;
    else if (lowCnt_r != 25'(STBY_CYC))
      lowCnt_r <= lowCnt_r + 25'h1;
  // reset always lands in active
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      state_r <= MDSC_ST_ACTIVE;
    else
      case (state_r)
        MDSC_ST_ACTIVE:
          if (lowCond && lowCnt_r == 25'(STBY_CYC))
            state_r <= MDSC_ST_STANDBY;
        MDSC_ST_STANDBY:
          if (wake)
            state_r <= MDSC_ST_ACTIVE;
        default:
          state_r <= MDSC_ST_ACTIVE;
      endcase
  assign standby   = (state_r == MDSC_ST_STANDBY);
  assign powerDown = standby;
  // a register demand holds until a standby round trip; set wins
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      twoWire_r <= 1'b0;
    else if (ovr.demandSel)
      twoWire_r <= 1'b1;
    else if (standby && wake)
      twoWire_r <= 1'b0;
  assign twoWireDemand = twoWire_r;

  //----------------------------------------------------------------
  // direction and brake drive
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      phaseFwd     <= 1'b1;
      lowSideAllOn <= 1'b0;
    end
    else
    begin
      // direction may change while running
      phaseFwd     <= ovr.dirOvrEn ? (ovr.regDir ^ pinSync[1]) : pinSync[1];
      lowSideAllOn <= brakeReq && (!cfg.safeBrakeEn ||
                      motorSpeed <= cfg.safeBrakeSpeed);
    end
  assign brakeOn = lowSideAllOn;

  //----------------------------------------------------------------
  // soft on/off ramp
  //----------------------------------------------------------------
  logic [15:0] rampCnt_r;   // step period divider
  logic        rampTick;    // one-cycle step enable
  assign rampTick = (rampCnt_r == 16'(`MDSC_RAMP_CYC - 1));
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      rampCnt_r <= 16'h0;
    else
      rampCnt_r <= rampTick ? 16'h0 : rampCnt_r + 16'h1;
  // a start from zero without windmillFwd jumps to full scale; windmill starts and restarts from a nonzero scale ramp
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      currentScale <= 10'h0;
    else if (!cfg.softRampOnOff)
      currentScale <= motorRun ? `MDSC_FULL : 10'h0;
    else if (motorRun && currentScale != `MDSC_FULL)
    begin
      if (currentScale == 10'h0 && !windmillFwd)
        currentScale <= `MDSC_FULL;
      else if (rampTick)
        currentScale <= (currentScale > `MDSC_FULL - `MDSC_RAMP_STEP) ?
                        `MDSC_FULL : currentScale + `MDSC_RAMP_STEP;
    end
    else if (!motorRun && rampTick && currentScale != 10'h0)
      currentScale <= (currentScale < `MDSC_RAMP_STEP) ?
                      10'h0 : currentScale - `MDSC_RAMP_STEP;

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_run_restart: assert property ($rose(runEn_r) |->
    $past(demand) > mdsc_thr($past(cfg.thrSel), 1'b1)) else $error("restart below on level");
  a_clk_err_stop: assert property (clkErr_r |-> !motorRun)
    else $error("motor runs with clock error");
  a_brake_stop: assert property (brakeOn && brakeReq |-> !motorRun)
    else $error("motor runs while braking");
  a_safe_brake: assert property ($rose(lowSideAllOn) && $past(cfg.safeBrakeEn) |->
    $past(motorSpeed) <= $past(cfg.safeBrakeSpeed)) else $error("unsafe brake");
  a_stby_entry: assert property ($rose(standby) |->
    $past(cfg.standbyEn) && !$past(brakeReq) && $past(lowCnt_r) == 25'(STBY_CYC))
    else $error("bad standby entry");
  a_dir_plain: assert property (!ovr.dirOvrEn ##1 !ovr.dirOvrEn |->
    phaseFwd == $past(pinSync[1])) else $error("phase order wrong");
  a_wire_hold: assert property ($fell(twoWire_r) |->
    $past(standby) && !standby) else $error("register demand dropped early");
  a_clk_target: assert property (clkMode && !twoWire_r ##1 clkMode |->
    tgt.loopTarget == $past(rpmVal)) else $error("clock target wrong");
  a_pwr_down: assert property (standby |-> powerDown && !motorRun)
    else $error("standby not powered down");
  a_ramp_down: assert property ($past(cfg.softRampOnOff) && cfg.softRampOnOff && !motorRun |->
    currentScale + `MDSC_RAMP_STEP >= $past(currentScale)) else $error("ramp too steep");
  c_standby: cover property ($rose(standby));
  c_wake: cover property ($fell(standby));
  c_clk_err: cover property ($rose(clkErr_r));
  c_brake: cover property ($rose(lowSideAllOn));
endmodule : mdsc_core

// [bench/mdsc_host_model.sv]
// host side model: drives the demand pin as pwm or as a plain level
`timescale 1ns/1ns
module mdsc_host_model (
  input  wire logic       ref_clk,
  input  wire logic       pwmEn,     // 1: pwm, 0: static level
  input  wire logic [7:0] hiCyc,     // high cycles of a 256-cycle period
  input  wire logic       pinLevel,  // level while pwm is off
  output logic            demandPin
);
  logic [7:0] phase = 8'h00;  // 256 cycles: about 78 khz, so range 0 applies
  // ----------------------------------------
  // pwm generator, edges launched off the sampling edge
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    phase <= phase + 8'h01;
    demandPin <= #5 pwmEn ? (phase < hiCyc) : pinLevel;
  end
endmodule : mdsc_host_model

// [bench/mdsc_core_bench.sv]
// self-checking bench of the demand front end
`timescale 1ns/1ns
module mdsc_core_bench;
  import mdsc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, dirPin = 1'b1, brakePin = 1'b0;
  logic pwmEn = 1'b0, pinLevel = 1'b0, demandPin;
  logic [7:0] hiCyc = 8'h00;
  logic [8:0] adcCode = 9'h000;
  mdsc_cfg_s cfg = '0;
  mdsc_ovr_s ovr = '0;
  mdsc_tgt_s tgt;
  logic standby, powerDown, phaseFwd, lowSideAllOn, motorRun, clkInputErr;
  logic satVoltage, satCurrent, twoWireDemand, sclLine;
  logic [9:0] currentScale;
  logic [15:0] motorSpeed = 16'h0000;
  logic motorStill = 1'b1, windmillFwd = 1'b0, curLimitActive = 1'b0, maxVoltReached = 1'b0;
  int mismatches = 0, tests_run = 0, seed;
  always #25 ref_clk = ~ref_clk;  // 20 mhz
  mdsc_host_model host_u (.ref_clk(ref_clk), .pwmEn(pwmEn), .hiCyc(hiCyc),
    .pinLevel(pinLevel), .demandPin(demandPin));
  // short standby count keeps the run brief; timeouts exceed the pwm period;
  // the gate spans exactly two pwm periods, so the edge count is always two
  mdsc_core #(.STBY_CYC(200), .GATE_CYC(512), .TOUT_HI_CYC(400), .TOUT_LO_CYC(800)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .demandPin(demandPin), .dirPin(dirPin),
    .brakePin(brakePin), .adcCode(adcCode), .cfg(cfg), .ovr(ovr),
    .motorSpeed(motorSpeed), .motorStill(motorStill), .windmillFwd(windmillFwd),
    .curLimitActive(curLimitActive), .maxVoltReached(maxVoltReached), .tgt(tgt),
    .motorRun(motorRun), .clkInputErr(clkInputErr), .standby(standby),
    .powerDown(powerDown), .phaseFwd(phaseFwd), .lowSideAllOn(lowSideAllOn),
    .currentScale(currentScale), .satVoltage(satVoltage), .satCurrent(satCurrent),
    .twoWireDemand(twoWireDemand), .sclLine(sclLine));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : cyc
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic doReset();
    rst = 1'b1;
    cyc(10);
    rst = 1'b0;
    cyc(3);
  endtask : doReset
  // bounded wait for the standby state
  task automatic waitStby(input logic v);
    int i;
    for (i = 0; i < 600 && standby !== v; i++)
      cyc(1);
    if (standby !== v)
    begin
      mismatches++;
      $display("CHECK FAILED standby expected %b seen %b", v, standby);
      final_report();
    end
  endtask : waitStby
  // demand on the 512 scale equals loopTarget with full scale 512
  function automatic logic [19:0] dutyExp(input logic [7:0] h);
    return 20'(h) * 20'h00002;
  endfunction : dutyExp
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = $urandom(32'h054c76c0);
    cfg.loop = MDSC_LOOP_SPEED;
    cfg.loopFullScale = 16'h0200;
    cfg.demandFullScaleVoltage = 9'h100;
    cfg.stillChkEn = 1'b1;
    doReset();
    chk("phaseFwd", 20'h1, phaseFwd);
    chk("standby", 20'h0, standby);
    dirPin = 1'b0;
    cyc(4);
    chk("phaseFwd", 20'h0, phaseFwd);
    ovr.dirOvrEn = 1'b1;
    ovr.regDir = 1'b1;
    cyc(4);
    chk("phaseFwd", 20'h1, phaseFwd);
    ovr = '0;
    brakePin = 1'b1;
    cyc(4);
    chk("lowSideAllOn", 20'h1, lowSideAllOn);
    ovr.haltOverrideEn = 1'b1;
    cyc(4);
    chk("lowSideAllOn", 20'h0, lowSideAllOn);
    ovr.regHalt = 1'b1;
    cyc(4);
    chk("lowSideAllOn", 20'h1, lowSideAllOn);
    ovr = '0;
    brakePin = 1'b0;
    // pin low and rotor still, but standby is disabled
    cyc(300);
    chk("standby", 20'h0, standby);
    $display("test direction and brake done");
    // duty sweep: both extremes, then random high times
    pwmEn = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      hiCyc = (k == 0) ? 8'hff : (k == 1) ? 8'h01 : 8'($urandom_range(2, 254));
      cyc(800);
      chk("loopTarget duty", dutyExp(hiCyc), tgt.loopTarget);
    end
    $display("test duty done");
    // hysteresis walk 42, 34, 28, 34, 42 of 512; soft start on the last step
    for (int k = 0; k < 5; k++)
    begin
      hiCyc = (k == 1 || k == 3) ? 8'h11 : (k == 2) ? 8'h0e : 8'h15;
      cfg.softRampOnOff = (k == 4);
      windmillFwd = (k == 4);
      cyc(800);
      chk("motorRun", 20'(k < 2 || k == 4), motorRun);
    end
    chk("scale ramp", 20'h1, 20'(currentScale inside {[10'h001:10'h1ff]}));
    cyc(13000);
    chk("currentScale", 20'h200, currentScale);
    cfg.softRampOnOff = 1'b0;
    windmillFwd = 1'b0;
    // saturation report: voltage ceiling, then current limit takes over
    maxVoltReached = 1'b1;
    cyc(2);
    chk("satVoltage", 20'h1, satVoltage);
    curLimitActive = 1'b1;
    cyc(2);
    chk("satCurrent", 20'h1, satCurrent);
    chk("satVoltage", 20'h0, satVoltage);
    maxVoltReached = 1'b0;
    curLimitActive = 1'b0;
    // safe brake holds off while the rotor is fast
    cfg.safeBrakeEn = 1'b1;
    cfg.safeBrakeSpeed = 16'h0100;
    motorSpeed = 16'h0200;
    brakePin = 1'b1;
    cyc(4);
    chk("motorRun", 20'h0, motorRun);
    chk("lowSideAllOn", 20'h0, lowSideAllOn);
    motorSpeed = 16'h0080;
    cyc(2);
    chk("lowSideAllOn", 20'h1, lowSideAllOn);
    brakePin = 1'b0;
    cfg.safeBrakeEn = 1'b0;
    $display("test stop, ramp and brake done");
    // clock mode: two edges per gate, so rpm is twice the ratio
    cfg.mode = MDSC_MODE_CLOCK;
    cfg.loop = MDSC_LOOP_OPEN;
    cfg.clkRatio = 8'h37;
    cfg.ratedSpeed = 16'h0100;
    cyc(4);
    chk("loopTarget clock", 20'h0006e, tgt.loopTarget);
    chk("clkInputErr", 20'h0, clkInputErr);
    cfg.ratedSpeed = 16'h0030;
    cyc(4);
    chk("clkInputErr", 20'h1, clkInputErr);
    chk("motorRun", 20'h0, motorRun);
    // register demand takes over and sticks after the select drops
    cfg.loop = MDSC_LOOP_SPEED;
    ovr.regDemand = 9'h0a0;
    ovr.demandSel = 1'b1;
    cyc(2);
    ovr.demandSel = 1'b0;
    cyc(4);
    chk("twoWireDemand", 20'h1, twoWireDemand);
    chk("loopTarget register", 20'h000a0, tgt.loopTarget);
    $display("test clock and register demand done");
    pwmEn = 1'b0;
    ovr = '0;
    rst = 1'b1;
    cfg.mode = MDSC_MODE_ANALOG;
    doReset();
    for (int k = 0; k < 4; k++)
    begin
      adcCode = 9'($urandom_range(0, 255));
      if (k < 2)
        cfg.loop = MDSC_LOOP_SPEED;
      else
        cfg.loop = MDSC_LOOP_OPEN;
      cyc(20);
      chk("analog target", (k < 2) ? 20'(adcCode) * 20'h2 : 20'h0, tgt.loopTarget);
      chk("openAmp", (k < 2) ? 20'h0 : 20'(adcCode) * 20'h2, tgt.openAmp);
    end
    $display("test analog done");
    rst = 1'b1;
    cfg.mode = MDSC_MODE_DUTY;
    cfg.standbyEn = 1'b1;
    doReset();
    chk("sclLine", 20'h0, sclLine);
    ovr.regDemand = 9'h0a0;
    ovr.demandSel = 1'b1;
    cyc(1);
    ovr.demandSel = 1'b0;
    // braking, then a turning rotor, each hold standby off
    brakePin = 1'b1;
    cyc(300);
    chk("standby", 20'h0, standby);
    brakePin = 1'b0;
    motorStill = 1'b0;
    cyc(300);
    chk("standby", 20'h0, standby);
    motorStill = 1'b1;
    waitStby(1'b1);
    chk("powerDown", 20'h1, powerDown);
    chk("twoWireDemand", 20'h1, twoWireDemand);
    pinLevel = 1'b1;
    waitStby(1'b0);
    chk("twoWireDemand", 20'h0, twoWireDemand);
    chk("sclLine", 20'h1, sclLine);
    $display("test standby done");
    final_report();
  end
endmodule : mdsc_core_bench
